// file: sim/accel_sample_state_control_tb.sv
/*
 * self-checking bench for the motion sensor readout block.
 * assumes the host model drives the serial link; raw samples change only while the block is idle.
 */
`timescale 1ns/10ps
`default_nettype none
module accel_sample_state_control_tb;
    localparam int SAMPLE_CYCLES = 200;

    logic                  clk_in;
    logic                  rst_in;
    logic                  link_clk_in;
    logic                  scl_wire;
    logic                  sda_wire;
    logic                  dev_sda;
    logic                  dev_sda_drive_n;
    logic                  int_n;
    asc_pkg::asc_axes_type raw_sample_in;
    logic [15:0]           xs;
    int                    err_count;
    int                    total_checks;

    asc_core #(
        .SAMPLE_CYCLES(SAMPLE_CYCLES)
    ) i_asc_core (
        .clk_in                     (clk_in),
        .rst_in                     (rst_in),
        .link_clk_in                (link_clk_in),
        .scl_in                     (scl_wire),
        .sda_in                     (sda_wire),
        .raw_sample_in              (raw_sample_in),
        .sda_out                    (dev_sda),
        .sda_drive_n_out            (dev_sda_drive_n),
        .interrupt_output_pin_n_out (int_n)
    );

    asc_host_model i_asc_host_model (
        .link_clk_in        (link_clk_in),
        .dev_sda_in         (dev_sda),
        .dev_sda_drive_n_in (dev_sda_drive_n),
        .scl_out            (scl_wire),
        .sda_out            (sda_wire)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial
    begin
        link_clk_in = 1'b0;
        #37;
        forever #62.5 link_clk_in = ~link_clk_in;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        i_asc_host_model.read_regs(ptr, 1);
        chk_byte($sformatf("register %h", ptr), exp,
                 i_asc_host_model.rd_data[0]);
    endtask

    // one burst over all six result bytes, low byte at the even offset
    task automatic chk_results(input logic [15:0] ex, input logic [15:0] ey,
                               input logic [15:0] ez);
        logic [47:0] w;
        w = {ez, ey, ex};
        i_asc_host_model.read_regs(8'h00, 6);
        for (int i = 0; i < 6; i++)
            chk_byte($sformatf("result byte %0d", i), w[8 * i +: 8],
                     i_asc_host_model.rd_data[i]);
    endtask

    task automatic wait_samples(input int n);
        repeat (n * SAMPLE_CYCLES) @(posedge clk_in);
        #1;
    endtask

    initial
    begin
        #2000000;
        err_count++;
        $display("Error watchdog expected done seen timeout");
        end_of_test();
    end

    initial
    begin
        rst_in        = 1'b1;
        raw_sample_in = {16'h7fff, 16'hfc00, 16'h0400};
        err_count     = 0;
        total_checks  = 0;
        xs            = 16'h0000;
        repeat (2) @(posedge clk_in);
        repeat (3) @(posedge link_clk_in);
        @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        repeat (8) @(posedge link_clk_in);
        wait_samples(4);
        chk_bit("interrupt pin", 1'b1, int_n);
        rd_chk(8'h07, 8'h03);
        // 2 g, 4 g and 8 g in 10-bit resolution; z clamps at the top
        for (int r = 0; r < 3; r++)
        begin
            xs = 16'h0400 >> (r + 2);
            i_asc_host_model.write_reg(8'h08, r[7:0]);
            i_asc_host_model.write_reg(8'h07, 8'h05);
            wait_samples(4);
            chk_bit("interrupt pin", 1'b0, int_n);
            chk_results(xs, 16'h0000 - xs, 16'h01ff);
            if (r == 0)
            begin
                i_asc_host_model.write_reg(8'h08, 8'h04);
                rd_chk(8'h08, 8'h00);
            end
            i_asc_host_model.write_reg(8'h07, 8'h07);
        end
        @(posedge clk_in);
        #1;
        raw_sample_in = {16'h7fff, 16'h0123, 16'h8001};
        wait_samples(4);
        chk_results(16'h0040, 16'hffc0, 16'h01ff);
        wait_samples(4);
        chk_bit("interrupt pin", 1'b1, int_n);
        i_asc_host_model.write_reg(8'h08, 8'h04);
        i_asc_host_model.write_reg(8'h07, 8'h05);
        wait_samples(4);
        chk_results(16'he000, 16'h0123, 16'h1fff);
        rd_chk(8'h06, 8'h00);
        chk_byte("missing acks", 8'h00, i_asc_host_model.nack_count[7:0]);
        end_of_test();
    end
endmodule // accel_sample_state_control_tb
`default_nettype wire

// file: sim/asc_host_model.sv
/*
 * host side of the two-wire register link: start, stop, byte transfers,
 * register write and burst read tasks called by the bench.
 * assumes a pull-up on the data wire and a free-running link clock.
 */
`timescale 1ns/10ps
`default_nettype none
module asc_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
    input  wire logic link_clk_in,
    input  wire logic dev_sda_in,
    input  wire logic dev_sda_drive_n_in,
    output logic      scl_out,
    output logic      sda_out
);
    logic       sda_host_reg;
    logic [7:0] rd_data [0:5];
    int         nack_count;

    // pulled-up wire: low while either side pulls it
    assign sda_out = sda_host_reg & (dev_sda_drive_n_in | dev_sda_in);

    initial
    begin
        scl_out      = 1'b1;
        sda_host_reg = 1'b1;
        nack_count   = 0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk_in);
        #1;
    endtask

    // start and repeated start: data falls while clock high
    task automatic start_cond();
        ticks(2);
        sda_host_reg = 1'b1;
        ticks(2);
        scl_out = 1'b1;
        ticks(4);
        sda_host_reg = 1'b0;
        ticks(4);
        scl_out = 1'b0;
    endtask

    // stop closes every transfer, so results may reload between reads
    task automatic stop_cond();
        ticks(2);
        sda_host_reg = 1'b0;
        ticks(2);
        scl_out = 1'b1;
        ticks(4);
        sda_host_reg = 1'b1;
        ticks(4);
    endtask

    // nine clocks, half periods of four link clocks, data held past fall
    task automatic xfer(input logic [8:0] bits_out, output logic [8:0] seen);
        for (int i = 8; i >= 0; i--)
        begin
            ticks(2);
            sda_host_reg = bits_out[i];
            ticks(2);
            scl_out = 1'b1;
            ticks(4);
            seen[i] = sda_out;
            scl_out = 1'b0;
        end
    endtask

    task automatic send(input logic [7:0] b);
        logic [8:0] seen;
        xfer({b, 1'b1}, seen);
        if (seen[0] !== 1'b0)
            nack_count++;
    endtask

    // mode writes and idle-only config writes are ordered by the caller
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
        start_cond();
        send({DEV_ADDR, 1'b0});
        send(ptr);
        send(data);
        stop_cond();
    endtask

    // pointer write, repeated start, n bytes; the last one is not acked
    task automatic read_regs(input logic [7:0] ptr, input int n);
        logic [8:0] seen;
        start_cond();
        send({DEV_ADDR, 1'b0});
        send(ptr);
        start_cond();
        send({DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            xfer({8'hff, i == n - 1}, seen);
            rd_data[i] = seen[8:1];
        end
        stop_cond();
    endtask
endmodule // asc_host_model
`default_nettype wire

// file: verilog/asc_core.sv
/*
 * motion sensor readout: serial slave, mode and output configuration,
 * sample timing, low-pass filter, scaling, saturation, sample interrupt.
 * assumes raw_sample_in is on clk_in at 1024 lsb per g, and scl/sda are
 * oversampled on link_clk_in, which runs freely.
 */
`timescale 1ns/10ps
`default_nettype none

module asc_core #(
    parameter logic [6:0] SLAVE_ADDR    = 7'h2a, // arbitrary value
    parameter int         SAMPLE_CYCLES = asc_pkg::SAMPLE_CYCLES
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 link_clk_in,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    input  wire asc_pkg::asc_axes_type raw_sample_in,
    output logic                      sda_out,
    output logic                      sda_drive_n_out,
    output logic                      interrupt_output_pin_n_out
);

    localparam int CW = $clog2(SAMPLE_CYCLES);
    localparam logic [CW-1:0] TMR_LAST = CW'(SAMPLE_CYCLES - 1);

    // link domain
    logic [1:0]                  lrst_reg;
    logic [2:0]                  scl_reg;
    logic [2:0]                  sda_reg;
    asc_pkg::asc_link_state_type state_reg;
    logic [3:0]                  cnt_reg;
    logic [7:0]                  shf_reg;
    logic [7:0]                  ptr_reg;
    logic                        ptr_phase_reg;
    logic                        rw_reg;
    logic                        drive_reg;
    logic [7:0]                  mode_reg;
    logic [7:0]                  output_config_register_reg;
    logic                        wake_reg;
    asc_pkg::asc_axes_type       res_reg;
    logic                        stop_seen_reg;
    logic                        int_reg;
    logic [2:0]                  tog_sync_reg;
    logic                        ack_tog_reg;

    // core domain
    logic [1:0]                  wake_sync_reg;
    logic [7:0]                  cfg_s1_reg;
    logic [7:0]                  cfg_s2_reg;
    logic [1:0]                  ack_sync_reg;
    logic [CW-1:0]               tmr_reg;
    logic                        tick_d_reg;
    logic [5:0]                  dec_reg;
    asc_pkg::asc_axes_type       smp_reg;
    logic                        smp_int_reg;
    logic                        smp_tog_reg;

    wire logic link_rst = lrst_reg[1];
    wire logic scl_rise = scl_reg[1] & ~scl_reg[2];
    wire logic scl_fall = ~scl_reg[1] & scl_reg[2];
    wire logic scl_high = scl_reg[1] & scl_reg[2];
    wire logic start_evt = scl_high & sda_reg[2] & ~sda_reg[1];
    wire logic stop_evt = scl_high & ~sda_reg[2] & sda_reg[1];
    wire logic sda_bit = sda_reg[1];
    wire logic byte_done = scl_fall && cnt_reg == 4'h8;
    wire logic addr_ok = shf_reg[7:1] == SLAVE_ADDR;
    wire logic wr_evt = state_reg == asc_pkg::ST_WR && byte_done
                        && !ptr_phase_reg;
    wire logic mode_wr = wr_evt && ptr_reg == asc_pkg::REG_MODE;
    wire logic cfg_wr = wr_evt && ptr_reg == asc_pkg::REG_OUTPUT_CONFIG_REGISTER
                        && !wake_reg;
    wire logic read_open = state_reg == asc_pkg::ST_ADDR && byte_done
                           && addr_ok && shf_reg[0];
    wire logic new_smp = tog_sync_reg[1] ^ tog_sync_reg[2];
    wire logic update = new_smp & stop_seen_reg;
    wire logic [47:0] res_flat = res_reg;
    wire logic [7:0] res_byte = res_flat[{ptr_reg[2:0], 3'h0} +: 8];
    wire logic [7:0] rdata =
        (ptr_reg <= asc_pkg::REG_RESULT_LAST) ? res_byte :
        (ptr_reg == asc_pkg::REG_MODE)        ? mode_reg :
        (ptr_reg == asc_pkg::REG_OUTPUT_CONFIG_REGISTER)      ? output_config_register_reg : 8'h00;

    assign sda_out = 1'b0;
    assign sda_drive_n_out = ~drive_reg;
    assign interrupt_output_pin_n_out = ~int_reg;

    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lrst_reg <= 2'h3;
        end
        else
        begin
            lrst_reg <= {lrst_reg[0], 1'b0};
        end
    end

    always_ff @(posedge link_clk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
            tog_sync_reg <= 3'h0;
        end
        else
        begin
            scl_reg <= {scl_reg[1:0], scl_in};
            sda_reg <= {sda_reg[1:0], sda_in};
            tog_sync_reg <= {tog_sync_reg[1:0], smp_tog_reg};
        end
    end

    // serial slave: sample on scl rise, drive on scl fall
    always_ff @(posedge link_clk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            state_reg <= asc_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            shf_reg <= 8'h00;
            ptr_reg <= 8'h00;
            ptr_phase_reg <= 1'b0;
            rw_reg <= 1'b0;
            drive_reg <= 1'b0;
        end
        else if (start_evt)
        begin
            state_reg <= asc_pkg::ST_ADDR;
            cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
        end
        else if (stop_evt)
        begin
            state_reg <= asc_pkg::ST_IDLE;
            drive_reg <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_reg == asc_pkg::ST_ADDR || state_reg == asc_pkg::ST_WR)
            begin
                shf_reg <= {shf_reg[6:0], sda_bit};
                cnt_reg <= cnt_reg + 4'h1;
            end
            else if (state_reg == asc_pkg::ST_RD)
            begin
                cnt_reg <= cnt_reg + 4'h1;
            end
            else if (state_reg == asc_pkg::ST_RACK && sda_bit)
            begin
                state_reg <= asc_pkg::ST_IDLE;
            end
        end
        else if (scl_fall)
        begin
            unique case (state_reg)
                asc_pkg::ST_ADDR:
                    if (cnt_reg == 4'h8)
                    begin
                        state_reg <= addr_ok ? asc_pkg::ST_AACK
                                             : asc_pkg::ST_IDLE;
                        drive_reg <= addr_ok;
                        rw_reg <= shf_reg[0];
                        ptr_phase_reg <= 1'b1;
                    end
                asc_pkg::ST_WR:
                    if (cnt_reg == 4'h8)
                    begin
                        state_reg <= asc_pkg::ST_AACK;
                        drive_reg <= 1'b1;
                        ptr_reg <= ptr_phase_reg ? shf_reg
                                                 : ptr_reg + 8'h01;
                        ptr_phase_reg <= 1'b0;
                    end
                asc_pkg::ST_AACK, asc_pkg::ST_RACK:
                begin
                    cnt_reg <= 4'h0;
                    state_reg <= rw_reg ? asc_pkg::ST_RD : asc_pkg::ST_WR;
                    drive_reg <= rw_reg & ~rdata[7];
                    shf_reg <= {rdata[6:0], 1'b0};
                    ptr_reg <= rw_reg ? ptr_reg + 8'h01 : ptr_reg;
                end
                asc_pkg::ST_RD:
                begin
                    drive_reg <= (cnt_reg != 4'h8) & ~shf_reg[7];
                    shf_reg <= {shf_reg[6:0], 1'b0};
                    if (cnt_reg == 4'h8)
                    begin
                        state_reg <= asc_pkg::ST_RACK;
                    end
                end
                asc_pkg::ST_IDLE: ;
            endcase
        end
    end

    // registers, state control, result update, interrupt pin
    always_ff @(posedge link_clk_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            mode_reg <= asc_pkg::MODE_RESET;
            output_config_register_reg <= asc_pkg::OUTPUT_CONFIG_REGISTER_RESET;
            wake_reg <= 1'b0;
            res_reg <= '0;
            stop_seen_reg <= 1'b1;
            int_reg <= 1'b0;
            ack_tog_reg <= 1'b0;
        end
        else
        begin
            if (mode_wr)
            begin
                mode_reg <= shf_reg;
                if (shf_reg[1:0] == asc_pkg::OPERATING_STATE_FIELD_WAKE)
                begin
                    wake_reg <= 1'b1;
                end
                else if (shf_reg[1:0] == asc_pkg::OPERATING_STATE_FIELD_IDLE)
                begin
                    wake_reg <= 1'b0;
                end
            end
            if (cfg_wr)
            begin
                output_config_register_reg <= shf_reg;
            end
            if (update)
            begin
                res_reg <= smp_reg;
            end
            ack_tog_reg <= ack_tog_reg ^ new_smp;
            stop_seen_reg <= stop_evt | (stop_seen_reg & ~update);
            int_reg <= (update & smp_int_reg & wake_reg
                        & mode_reg[asc_pkg::MODE_SAMPLE_UPDATE_INTERRUPT_BIT])
                       | (int_reg & ~read_open);
        end
    end

    // core domain: settings cross as quasi-static levels
    wire logic wake_s = wake_sync_reg[1];
    wire logic res14 = cfg_s2_reg[asc_pkg::OUTPUT_CONFIG_REGISTER_RES14_BIT];
    wire logic interrupt_rate_select = cfg_s2_reg[asc_pkg::OUTPUT_CONFIG_REGISTER_INTERRUPT_RATE_SELECT_BIT];
    wire logic [1:0] range = cfg_s2_reg[1:0];
    wire logic [2:0] lpf_raw = cfg_s2_reg[asc_pkg::OUTPUT_CONFIG_REGISTER_LPF_LSB +: 3];
    wire logic [2:0] lpf_k = (lpf_raw > asc_pkg::LPF_MAX)
                             ? asc_pkg::LPF_MAX : lpf_raw;
    wire logic [5:0] dec_mask = 6'((7'h01 << lpf_k) - 7'h01);
    wire logic sample_update_interrupt_due = !interrupt_rate_select || dec_reg == dec_mask;
    wire logic [3:0] shift = res14 ? asc_pkg::SHIFT_14B :
                             (range == asc_pkg::RANGE_2G) ? asc_pkg::SHIFT_2G :
                             (range == asc_pkg::RANGE_4G) ? asc_pkg::SHIFT_4G :
                             asc_pkg::SHIFT_8G;
    wire logic [15:0] sat_hi = res14 ? asc_pkg::SAT14_MAX : asc_pkg::SAT10_MAX;
    wire logic [15:0] sat_lo = res14 ? asc_pkg::SAT14_MIN : asc_pkg::SAT10_MIN;
    wire logic tick = wake_s && tmr_reg == '0;
    wire logic busy = smp_tog_reg != ack_sync_reg[1];
    wire logic capture = tick_d_reg & ~busy;
    wire logic [15:0] raw_a [3];
    wire logic [15:0] sat_w [3];

    assign raw_a[0] = raw_sample_in.x;
    assign raw_a[1] = raw_sample_in.y;
    assign raw_a[2] = raw_sample_in.z;

    for (genvar i = 0; i < 3; i++)
    begin : g_axis
        logic signed [22:0] filt_reg;
        wire logic signed [22:0] xq = {raw_a[i][15], raw_a[i], 6'h00};
        wire logic signed [22:0] diff = xq - filt_reg;
        wire logic signed [15:0] f16 = filt_reg[21:6];
        wire logic signed [15:0] scaled = f16 >>> shift;
        assign sat_w[i] = (scaled > $signed(sat_hi)) ? sat_hi :
                          (scaled < $signed(sat_lo)) ? sat_lo :
                          scaled;

        always_ff @(posedge clk_in or posedge rst_in)
        begin
            if (rst_in)
            begin
                filt_reg <= '0;
            end
            else if (tick)
            begin
                filt_reg <= filt_reg + (diff >>> lpf_k);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_sync_reg <= 2'h0;
            cfg_s1_reg <= asc_pkg::OUTPUT_CONFIG_REGISTER_RESET;
            cfg_s2_reg <= asc_pkg::OUTPUT_CONFIG_REGISTER_RESET;
            ack_sync_reg <= 2'h0;
            tmr_reg <= '0;
            tick_d_reg <= 1'b0;
        end
        else
        begin
            wake_sync_reg <= {wake_sync_reg[0], wake_reg};
            cfg_s1_reg <= output_config_register_reg;
            cfg_s2_reg <= cfg_s1_reg;
            ack_sync_reg <= {ack_sync_reg[0], ack_tog_reg};
            tmr_reg <= (!wake_s || tmr_reg == TMR_LAST)
                       ? '0 : tmr_reg + 1'b1;
            tick_d_reg <= tick;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            smp_reg <= '0;
            smp_int_reg <= 1'b0;
            smp_tog_reg <= 1'b0;
            dec_reg <= 6'h00;
        end
        else if (capture)
        begin
            smp_reg <= {sat_w[2], sat_w[1], sat_w[0]};
            smp_int_reg <= sample_update_interrupt_due;
            smp_tog_reg <= ~smp_tog_reg;
            dec_reg <= (dec_reg >= dec_mask) ? 6'h00 : dec_reg + 6'h01;
        end
    end

    a_first_sample_wake: assert property (@(posedge clk_in)
        disable iff (rst_in) $rose(wake_s) |-> tick)
        else $error("no sample at wake");
    a_sample_period: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wake_s && tmr_reg == TMR_LAST) ##1 wake_s |-> tick)
        else $error("sample period wrong");
    a_idle_frozen: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !wake_s && !tick_d_reg |=> $stable(smp_tog_reg))
        else $error("sample taken in idle");
    a_sign_ten: assert property (@(posedge clk_in)
        disable iff (rst_in)
        capture && !res14 |=> smp_reg.x[15:9] inside {7'h00, 7'h7f})
        else $error("10-bit sign not extended");
    a_sign_fourteen: assert property (@(posedge clk_in)
        disable iff (rst_in)
        capture && res14 |=> smp_reg.y[15:13] inside {3'h0, 3'h7})
        else $error("14-bit sign not extended");
    a_sat_ten: assert property (@(posedge clk_in)
        disable iff (rst_in)
        capture && !res14 |=> $signed(smp_reg.z) >= $signed(16'hfe00)
        && $signed(smp_reg.z) <= $signed(16'h01ff))
        else $error("10-bit saturation broken");
    a_sat_fourteen: assert property (@(posedge clk_in)
        disable iff (rst_in)
        capture && res14 |=> $signed(smp_reg.x) >= $signed(16'he000)
        && $signed(smp_reg.x) <= $signed(16'h1fff))
        else $error("14-bit saturation broken");
    a_cfg_locked: assert property (@(posedge link_clk_in)
        disable iff (link_rst)
        wake_reg && wr_evt && ptr_reg == asc_pkg::REG_OUTPUT_CONFIG_REGISTER
        |=> $stable(output_config_register_reg) && state_reg == asc_pkg::ST_AACK)
        else $error("config written while sampling");
    a_mode_force: assert property (@(posedge link_clk_in)
        disable iff (link_rst)
        mode_wr |=> wake_reg == ($past(shf_reg[1:0]) == 2'h1 ? 1'b1 :
        $past(shf_reg[1:0]) == 2'h3 ? 1'b0 : $past(wake_reg)))
        else $error("state field not obeyed");
    a_result_gate: assert property (@(posedge link_clk_in)
        disable iff (link_rst)
        !stop_seen_reg |=> $stable(res_reg))
        else $error("result updated without stop");

    c_wake: cover property (@(posedge clk_in) disable iff (rst_in)
        $rose(wake_s));
    c_update: cover property (@(posedge link_clk_in) disable iff (link_rst)
        update);
    c_blocked: cover property (@(posedge link_clk_in) disable iff (link_rst)
        wake_reg && wr_evt && ptr_reg == asc_pkg::REG_OUTPUT_CONFIG_REGISTER);
    c_int: cover property (@(posedge link_clk_in) disable iff (link_rst)
        $rose(int_reg));

endmodule // asc_core
`default_nettype wire

// file: verilog/asc_pkg.sv
/*
 * shared constants and types of the motion sensor readout block.
 * assumes a 125 MHz core clock and a register map reached over the
 * two-wire serial link.
 */
`default_nettype none
package asc_pkg;

    typedef struct packed {
        logic [15:0] z;
        logic [15:0] y;
        logic [15:0] x;
    } asc_axes_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_WR   = 3'b010,
        ST_RD   = 3'b110,
        ST_RACK = 3'b111
    } asc_link_state_type;

    // register map: x_result_low at 0, x_result_high at 1, y at 2/3, z at 4/5
    localparam logic [7:0] REG_RESULT_LAST = 8'h05;
    localparam logic [7:0] REG_MODE        = 8'h07;
    localparam logic [7:0] REG_OUTPUT_CONFIG_REGISTER      = 8'h08;

    localparam int MODE_SAMPLE_UPDATE_INTERRUPT_BIT     = 2;
    localparam int OUTPUT_CONFIG_REGISTER_RES14_BIT  = 2;
    localparam int OUTPUT_CONFIG_REGISTER_LPF_LSB    = 3;
    localparam int OUTPUT_CONFIG_REGISTER_INTERRUPT_RATE_SELECT_BIT  = 6;

    localparam logic [1:0] OPERATING_STATE_FIELD_WAKE = 2'h1;
    localparam logic [1:0] OPERATING_STATE_FIELD_IDLE = 2'h3;
    localparam logic [1:0] RANGE_2G   = 2'h0;
    localparam logic [1:0] RANGE_4G   = 2'h1;

    localparam logic [7:0] MODE_RESET   = 8'h03;
    localparam logic [7:0] OUTPUT_CONFIG_REGISTER_RESET = 8'h00;

    localparam logic [3:0] SHIFT_2G  = 4'h2;
    localparam logic [3:0] SHIFT_4G  = 4'h3;
    localparam logic [3:0] SHIFT_8G  = 4'h4;
    localparam logic [3:0] SHIFT_14B = 4'h0;
    localparam logic [2:0] LPF_MAX   = 3'h6;

    localparam logic [15:0] SAT10_MIN = 16'hfe00;
    localparam logic [15:0] SAT10_MAX = 16'h01ff;
    localparam logic [15:0] SAT14_MIN = 16'he000;
    localparam logic [15:0] SAT14_MAX = 16'h1fff;

    localparam int CLK_FREQ_HZ    = 125000000;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int SAMPLE_RATE_HZ = 1024;
    localparam int SAMPLE_CYCLES  = CLK_FREQ_HZ / SAMPLE_RATE_HZ;
    localparam int WAKE_TIME_NS   = 10000;
    localparam int WAKE_CYCLES    = WAKE_TIME_NS / CLK_PERIOD_NS;

endpackage
`default_nettype wire
